// file: src/tiv_top.sv
// Purpose: Time interval counter with a sub-second, seconds, minutes and hours timebase
// Assumes: Core bus is synchronous to clk_sys; clk_sys is the always-on clock
// Notes: Read data is registered, valid the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "tiv_cfg.svh"

module tiv_top
  import tiv_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TIV_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Special function register bus
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  // Interrupt system
  input wire logic irqEnable,
  input wire logic powerDown,
  output logic irqReq,
  output logic wakeReq
);

  tiv_state_t cur_q;
  tiv_state_t nxt_d;
  logic tick128;

  // Decoded write to one register address
  function automatic logic wrHit(input logic en, input logic [7:0] addr, input logic [7:0] target);
    wrHit = en && (addr == target);
  endfunction : wrHit

  // Counter that wraps at a limit; values above the limit wrap as well
  function automatic logic wraps(input tiv_byte_t val, input tiv_byte_t lim);
    wraps = (val >= lim);
  endfunction : wraps

  // Timebase keeps running from the always-on clock; phase restarts when time clock is off
  tiv_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clear(!cur_q.ctrl.clkEn),
    .tick(tick128)
  );

  always_comb begin
    logic subTick;
    logic secTick;
    logic minTick;
    logic hourTick;
    logic subOvf;
    logic secOvf;
    logic minOvf;
    logic ivTick;
    logic hwSet;
    logic hwIvEnClr;
    tiv_byte_t icntNext;
    subTick = 1'b0;
    secTick = 1'b0;
    minTick = 1'b0;
    hourTick = 1'b0;
    subOvf = 1'b0;
    secOvf = 1'b0;
    minOvf = 1'b0;
    ivTick = 1'b0;
    hwSet = 1'b0;
    hwIvEnClr = 1'b0;
    icntNext = cur_q.icnt;
    nxt_d = cur_q;

    // Time cascade, only while the time clock is enabled
    subTick = tick128 && cur_q.ctrl.clkEn;
    subOvf = subTick && wraps(cur_q.sub, `TIV_SUB_MAX);
    secTick = subOvf;
    secOvf = secTick && wraps(cur_q.sec, `TIV_SEC_MAX);
    minTick = secOvf;
    minOvf = minTick && wraps(cur_q.min, `TIV_MIN_MAX);
    hourTick = minOvf;

    if (subTick) begin
      nxt_d.sub = subOvf ? 8'h00 : cur_q.sub + 8'h01;
    end
    if (secTick) begin
      nxt_d.sec = secOvf ? 8'h00 : cur_q.sec + 8'h01;
    end
    if (minTick) begin
      nxt_d.min = minOvf ? 8'h00 : cur_q.min + 8'h01;
    end
    if (hourTick) begin
      nxt_d.hour = wraps(cur_q.hour, `TIV_HOUR_MAX) ? 8'h00 : cur_q.hour + 8'h01;
    end

    // Interval tick from the selected unit
    unique case (cur_q.ctrl.sel)
      `TIV_SEL_SUB: ivTick = subTick;
      `TIV_SEL_SEC: ivTick = secTick;
      `TIV_SEL_MIN: ivTick = minTick;
      `TIV_SEL_HOUR: ivTick = hourTick;
    endcase

    // Interval counter and match
    if (ivTick && cur_q.ctrl.ivEn) begin
      icntNext = cur_q.icnt + 8'h01;
      if (icntNext == cur_q.ival) begin
        hwSet = 1'b1;
        icntNext = 8'h00;
        hwIvEnClr = cur_q.ctrl.single;
      end
      nxt_d.icnt = icntNext;
    end

    // Software writes to control; the hardware set wins over a clearing write
    if (wrHit(sfrWrEn, sfrAddr, `TIV_ADDR_CTRL)) begin
      nxt_d.ctrl.clkEn = sfrWrData[`TIV_BIT_CLK_EN];
      nxt_d.ctrl.ivEn = sfrWrData[`TIV_BIT_IV_EN];
      nxt_d.ctrl.flag = sfrWrData[`TIV_BIT_FLAG];
      nxt_d.ctrl.single = sfrWrData[`TIV_BIT_SINGLE];
      nxt_d.ctrl.sel = sfrWrData[`TIV_BIT_SEL_HI:`TIV_BIT_SEL_LO];
    end
    if (hwSet) begin
      nxt_d.ctrl.flag = 1'b1;
    end
    if (hwIvEnClr) begin
      nxt_d.ctrl.ivEn = 1'b0;
    end

    // Interval value register
    if (wrHit(sfrWrEn, sfrAddr, `TIV_ADDR_IVAL)) begin
      nxt_d.ival = sfrWrData;
    end

    // Time preload only while the time clock is stopped
    if (!cur_q.ctrl.clkEn) begin
      if (wrHit(sfrWrEn, sfrAddr, `TIV_ADDR_SUB)) begin
        nxt_d.sub = sfrWrData;
      end
      if (wrHit(sfrWrEn, sfrAddr, `TIV_ADDR_SEC)) begin
        nxt_d.sec = sfrWrData;
      end
      if (wrHit(sfrWrEn, sfrAddr, `TIV_ADDR_MIN)) begin
        nxt_d.min = sfrWrData;
      end
      if (wrHit(sfrWrEn, sfrAddr, `TIV_ADDR_HOUR)) begin
        nxt_d.hour = sfrWrData;
      end
    end

    // A stopped time clock or interval enable holds the interval counter at zero
    if (!cur_q.ctrl.clkEn || !nxt_d.ctrl.clkEn) begin
      nxt_d.icnt = 8'h00;
    end
    if (!nxt_d.ctrl.ivEn) begin
      nxt_d.icnt = 8'h00;
    end

    // Registered read of the live values; reserved control bits read zero
    if (sfrRdEn) begin
      unique case (sfrAddr)
        `TIV_ADDR_CTRL: nxt_d.rdData = {2'b00, cur_q.ctrl};
        `TIV_ADDR_SUB: nxt_d.rdData = cur_q.sub;
        `TIV_ADDR_SEC: nxt_d.rdData = cur_q.sec;
        `TIV_ADDR_MIN: nxt_d.rdData = cur_q.min;
        `TIV_ADDR_HOUR: nxt_d.rdData = cur_q.hour;
        `TIV_ADDR_IVAL: nxt_d.rdData = cur_q.ival;
        default: nxt_d.rdData = 8'h00;
      endcase
    end

    // Interrupt request and power-down wake follow the flag
    nxt_d.irqReq = nxt_d.ctrl.flag && irqEnable;
    nxt_d.wakeReq = nxt_d.ctrl.flag && irqEnable && powerDown;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign sfrRdData = cur_q.rdData;
  assign irqReq = cur_q.irqReq;
  assign wakeReq = cur_q.wakeReq;

endmodule : tiv_top

`default_nettype wire

// file: src/tiv_cfg.svh
// Purpose: Constants of the time interval counter: register offsets, fields, reset values, limits, timing
// Assumes: Included by bare name from the package and the design modules
// Notes: One clock, clk_sys at 100 MHz; the 1/128 s timebase is divided down from it
//
// Overview of operation
// - Timebase select picks interval tick unit
// - Single-interval timeout clears interval enable
// - Repeat mode reloads counter at each timeout
// - Counter equals interval value sets flag
// - Flag at control bit 2 raises interrupt
// - Interval enable runs counter; clear zeroes it
// - Time clock enable lets time advance
// - Clearing time clock enable stops time, zeroes interval counter and divider; time registers hold
// - Time registers writable while clock disabled
// - Sub-second counts 0..127 then bumps seconds
// - Seconds count 0..59 then bump minutes
// - Minutes count 0..59 then bump hours
// - Hours count 0..23 then wrap
// - All registers zero after power-on
// - Interval counter advances on selected overflow
// - Runs from always-on clock, not core clock
// - Enabled flag during power-down wakes device
`ifndef TIV_CFG_SVH
`define TIV_CFG_SVH

// Register offsets on the special-function-register bus
`define TIV_ADDR_CTRL 8'ha1
`define TIV_ADDR_SUB 8'ha2
`define TIV_ADDR_SEC 8'ha3
`define TIV_ADDR_MIN 8'ha4
`define TIV_ADDR_HOUR 8'ha5
`define TIV_ADDR_IVAL 8'ha6

// Control register field positions
`define TIV_BIT_CLK_EN 0
`define TIV_BIT_IV_EN 1
`define TIV_BIT_FLAG 2
`define TIV_BIT_SINGLE 3
`define TIV_BIT_SEL_LO 4
`define TIV_BIT_SEL_HI 5

// Reset value of every register
`define TIV_RESET 8'h00

// Counting limits
`define TIV_SUB_MAX 8'h7f
`define TIV_SEC_MAX 8'h3b
`define TIV_MIN_MAX 8'h3b
`define TIV_HOUR_MAX 8'h17

// Timebase selections
`define TIV_SEL_SUB 2'h0
`define TIV_SEL_SEC 2'h1
`define TIV_SEL_MIN 2'h2
`define TIV_SEL_HOUR 2'h3

// Timing: 1/128 s at a 10 ns clock
`define TIV_CLK_PERIOD_NS 10
`define TIV_TICK_PERIOD_NS 7812500
`define TIV_TICK_CYCLES (`TIV_TICK_PERIOD_NS / `TIV_CLK_PERIOD_NS)
`define TIV_DIV_W 20

`endif

// file: src/tiv_pkg.sv
// Purpose: Types of the time interval counter
// Assumes: Constants come from tiv_cfg.svh
// Notes: Each module keeps all its state in one packed struct
`include "tiv_cfg.svh"

package tiv_pkg;

  typedef logic [7:0] tiv_byte_t;

  typedef struct packed {
    logic [1:0] sel;
    logic single;
    logic flag;
    logic ivEn;
    logic clkEn;
  } tiv_ctrl_t;

  typedef struct packed {
    tiv_ctrl_t ctrl;
    tiv_byte_t sub;
    tiv_byte_t sec;
    tiv_byte_t min;
    tiv_byte_t hour;
    tiv_byte_t ival;
    tiv_byte_t icnt;
    tiv_byte_t rdData;
    logic irqReq;
    logic wakeReq;
  } tiv_state_t;

  typedef struct packed {
    logic [`TIV_DIV_W-1:0] cnt;
    logic tick;
  } tiv_div_state_t;

endpackage : tiv_pkg

// file: src/tiv_tick_div.sv
// Purpose: Divides clk_sys down to a one-cycle pulse every 1/128 s
// Assumes: Synchronous clear restarts the phase
// Notes: Period is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
`include "tiv_cfg.svh"

module tiv_tick_div
  import tiv_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TIV_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Control
  input wire logic clear,
  // Timebase pulse
  output logic tick
);

  tiv_div_state_t cur_q;
  tiv_div_state_t nxt_d;

  always_comb begin
    nxt_d = cur_q;
    nxt_d.tick = 1'b0;
    if (clear) begin
      nxt_d.cnt = '0;
    end else if (cur_q.cnt == `TIV_DIV_W'(TICK_CYCLES - 1)) begin
      nxt_d.cnt = '0;
      nxt_d.tick = 1'b1;
    end else begin
      nxt_d.cnt = cur_q.cnt + `TIV_DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign tick = cur_q.tick;

endmodule : tiv_tick_div

`default_nettype wire

// file: bench/tiv_core_model.sv
// Purpose: Core-side model driving the register bus
// Assumes: One access at a time, launched after a rising edge
// Notes: Released write data shows its inverse so stale data never matches
`timescale 1ns/1ps
`default_nettype none

module tiv_core_model (
  // Clock
  input wire logic clk_sys,
  // Register bus
  output logic [7:0] sfrAddr,
  output logic sfrWrEn,
  output logic [7:0] sfrWrData,
  output logic sfrRdEn,
  input wire logic [7:0] sfrRdData
);
  initial begin
    sfrAddr = 8'h00;
    sfrWrEn = 1'b0;
    sfrWrData = 8'h00;
    sfrRdEn = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfrAddr <= a;
    sfrWrEn <= 1'b1;
    sfrWrData <= d;
    @(posedge clk_sys);
    sfrWrEn <= 1'b0;
    sfrWrData <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clk_sys);
    sfrRdEn <= 1'b0;
    // Data was registered at the taking edge and holds; take it one edge later, settled
    @(posedge clk_sys);
    d = sfrRdData;
  endtask : rd
endmodule : tiv_core_model
`default_nettype wire

// file: bench/tiv_top_sva.sv
// Purpose: Port-level assertions of the time interval counter
// Assumes: One clock domain
// Notes: Range check assumes software never loads out-of-range counts
`timescale 1ns/1ps
`default_nettype none

module tiv_top_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register bus
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrRdData,
  // Interrupt system
  input wire logic irqEnable,
  input wire logic powerDown,
  input wire logic irqReq,
  input wire logic wakeReq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence rd_at(logic [7:0] a);
    $past(sfrRdEn) && $past(sfrAddr) == a;
  endsequence
  sequence ival_wr_rd;
    sfrWrEn && sfrAddr == 8'ha6 ##2 sfrRdEn && sfrAddr == 8'ha6;
  endsequence
  wake_irq_a: assert property (wakeReq |-> irqReq) else $error("wake without irq");
  irq_mask_a: assert property (irqReq |-> $past(irqEnable)) else $error("irq masked");
  wake_pd_a: assert property (wakeReq |-> $past(powerDown)) else $error("wake awake");
  rd_hold_a: assert property (!$past(sfrRdEn) |-> $stable(sfrRdData)) else $error("data moved");
  rd_unmapped_a: assert property ((rd_at(8'ha0) or rd_at(8'ha7)) |-> sfrRdData == 8'h00)
    else $error("unmapped read");
  ctrl_rsvd_a: assert property (rd_at(8'ha1) |-> sfrRdData[7:6] == 2'h0) else $error("bits 7:6 set");
  sub_range_a: assert property (rd_at(8'ha2) |-> sfrRdData <= 8'h7f) else $error("sub over 127");
  ival_back_a: assert property (ival_wr_rd |-> ##1 sfrRdData == $past(sfrWrData, 3))
    else $error("interval readback");
endmodule : tiv_top_sva

bind tiv_top tiv_top_sva chk_i (.clk_sys, .rst_b, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn, .sfrRdData,
  .irqEnable, .powerDown, .irqReq, .wakeReq);
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Register-level test of the time interval counter
// Assumes: tiv_core_model drives the register bus
// Notes: Timebase shortened to 4 clocks per 1/128 s to keep the run short
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk_sys, rst_b, sfrWrEn, sfrRdEn, irqEnable, powerDown, irqReq, wakeReq;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, v, a;
  int errors, n_compared, s, m, d;
  tiv_core_model core (.clk_sys, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn, .sfrRdData);
  tiv_top #(.TICK_CYCLES(4)) dut (.clk_sys, .rst_b, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn,
    .sfrRdData, .irqEnable, .powerDown, .irqReq, .wakeReq);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  // Bounded wait for the interrupt request
  task automatic waitIrq();
    for (int i = 0; i < 40 && irqReq !== 1'b1; i++) @(negedge clk_sys);
    if (irqReq !== 1'b1) begin
      errors++;
      results();
    end
  endtask : waitIrq
  initial begin
    errors = 0;
    n_compared = 0;
    rst_b = 1'b0;
    irqEnable = 1'b1;
    powerDown = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (a = 8'ha0; a < 8'ha8; a++) begin
      core.rd(a, v);
      chk(v, 8'h00);
    end
    core.wr(8'ha6, 8'h01);
    // Preload d counters at their limit, so only selections up to d see an overflow
    for (s = 0; s < 4; s++) begin
      for (m = 0; m < 2 && m <= s; m++) begin
        d = s - m;
        core.wr(8'ha2, d >= 1 ? 8'h7f : 8'h00);
        core.wr(8'ha3, d >= 2 ? 8'h3b : 8'h00);
        core.wr(8'ha4, d >= 3 ? 8'h3b : 8'h00);
        core.wr(8'ha5, 8'h17);
        core.wr(8'ha1, 8'(8'h4b | (s << 4)));
        core.wr(8'ha3, 8'h05);
        repeat (8) @(negedge clk_sys);
        core.rd(8'ha1, v);
        chk(v, 8'(8'h0b + (s << 4) + (m == 0 ? 2 : 0)));
        core.wr(8'ha1, 8'h40);
        core.rd(8'ha3, v);
        chk(v, d == 1 ? 8'h01 : 8'h00);
        core.rd(8'ha5, v);
        chk(v, d == 3 ? 8'h00 : 8'h17);
      end
    end
    powerDown <= 1'b1;
    core.wr(8'ha6, 8'h02);
    core.rd(8'ha6, v);
    chk(v, 8'h02);
    core.wr(8'ha1, 8'h43);
    waitIrq();
    chk({7'h00, wakeReq}, 8'h01);
    core.wr(8'ha1, 8'h43);
    repeat (2) @(negedge clk_sys);
    chk({7'h00, irqReq}, 8'h00);
    waitIrq();
    core.rd(8'ha1, v);
    chk(v, 8'h07);
    // Flag still set; masking the enable must drop both requests
    irqEnable <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({6'h00, wakeReq, irqReq}, 8'h00);
    results();
  end
endmodule : tb_top
`default_nettype wire
